// ---- hdl/icc_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module icc_filter (
    input  wire logic mclk_i,    // System clock
    input  wire logic rst_n_i,   // Synchronous reset, active low
    input  wire logic ce_i,      // Clock enable
    input  wire logic pin_i,     // Raw capture pin
    input  wire logic filt_on_i, // Filter enable
    output logic      level_o    // Cleaned level
);
    import icc_pkg::*;

    logic       s1_q, s1_d;
    logic       s2_q, s2_d;
    logic       lvl_q, lvl_d;
    logic [2:0] cnt_q, cnt_d;

    // Two-stage synchroniser, then optional stability filter
    always_comb begin
        s1_d  = pin_i;
        s2_d  = s1_q;
        lvl_d = lvl_q;
        cnt_d = 3'h0;
        if (!filt_on_i) begin
            lvl_d = s2_q;
        end else if (s2_q != lvl_q) begin
            // Fourth consecutive differing sample takes the level
            if (cnt_q == FILT_LAST) begin
                lvl_d = s2_q;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    // State registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            lvl_q <= 1'b0;
            cnt_q <= 3'h0;
        end else if (ce_i) begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_o = lvl_q;
endmodule
`default_nettype wire

// ---- hdl/icc_pkg.sv ----
// What this block does
// - Each of the three capture channels has an enable bit (bits 6, 5, 4 for channels 2, 1, 0) and only detects edges while it is set.
// - A channel's event flag (bits 2, 1, 0 for channels 2, 1, 0) is set when its selected edge is seen on its input.
// - Hardware never clears an event flag; it holds until software writes 0, and software writes to flag bits act directly.
// - Each two-bit edge selector means 00 falling, 01 rising, 10 both edges, and 11 is reserved.
// - The edge selectors share one register, channel 2 in bits 5:4, channel 1 in 3:2 and channel 0 in 1:0, other bits reserved.
// - Each channel has a noise-filter enable at bits 6, 5, 4 for channels 2, 1, 0 that filters its input before edge detection.
// - Reset clears all three control registers, so channels are off, select falling edges, filters are off and flags are clear.
package icc_pkg;
    localparam int unsigned NUM_CHAN = 3;
    localparam logic [7:0] OFS_EN_FLAGS = 8'h92;
    localparam logic [7:0] OFS_EDGE_SEL = 8'h93;
    localparam logic [7:0] OFS_FILTER   = 8'h94;
    localparam logic [7:0] RST_EN_FLAGS = 8'h00;
    localparam logic [7:0] RST_EDGE_SEL = 8'h00;
    localparam logic [7:0] RST_FILTER   = 8'h00;
    localparam int unsigned ENABLE_LSB  = 4;
    localparam int unsigned FLAG_LSB    = 0;
    localparam int unsigned FILTER_LSB  = 4;
    localparam int unsigned EDGE_W      = 2;
    localparam int unsigned FILT_CYCLES = 4;
    localparam logic [2:0] FILT_LAST    = 3'h3;
    localparam logic [7:0] MASK_EN_FLAGS = 8'h77;
    localparam logic [7:0] MASK_EDGE_SEL = 8'h3f;
    localparam logic [7:0] MASK_FILTER   = 8'h70;
    typedef enum logic [1:0] {
        ICC_EDGE_FALL = 2'h0,
        ICC_EDGE_RISE = 2'h1,
        ICC_EDGE_BOTH = 2'h2,
        ICC_EDGE_RSVD = 2'h3
    } icc_edge_t;
endpackage

// ---- hdl/icc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module icc_top (
    input  wire logic       mclk_i,     // System clock, 50 MHz
    input  wire logic       rst_n_i,    // Synchronous reset, active low
    input  wire logic       ce_i,       // Clock enable, freezes state
    input  wire logic [7:0] sfr_addr_i, // Register address
    input  wire logic [7:0] sfr_wdata_i,// Write data
    input  wire logic       sfr_wr_i,   // Write strobe
    input  wire logic       sfr_rd_i,   // Read strobe
    output logic      [7:0] sfr_rdata_o,// Read data, registered
    input  wire logic [icc_pkg::NUM_CHAN-1:0] cap_pin_i, // Capture pins
    output logic [icc_pkg::NUM_CHAN-1:0] cap_strobe_o,   // Edge pulses
    output logic [icc_pkg::NUM_CHAN-1:0] cap_flag_o      // Event flags
);
    import icc_pkg::*;

    logic [7:0]          en_flags_q, en_flags_d;
    logic [7:0]          edge_sel_q, edge_sel_d;
    logic [7:0]          filter_q, filter_d;
    logic [7:0]          rdata_q, rdata_d;
    logic [NUM_CHAN-1:0] lvl;
    logic [NUM_CHAN-1:0] lvl_q, lvl_d;
    logic [NUM_CHAN-1:0] hit;
    logic [NUM_CHAN-1:0] strobe_q, strobe_d;

    // Selected edge test for one channel
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        unique case (icc_edge_t'(sel))
            ICC_EDGE_FALL: edge_hit = fall;
            ICC_EDGE_RISE: edge_hit = rise;
            ICC_EDGE_BOTH: edge_hit = rise || fall;
            ICC_EDGE_RSVD: edge_hit = 1'b0;
        endcase
    endfunction

    // Address decode shared by the write and read paths, one-hot result
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        reg_sel = 3'h0;
        if (a == OFS_EN_FLAGS) begin
            reg_sel = 3'h1;
        end
        if (a == OFS_EDGE_SEL) begin
            reg_sel = 3'h2;
        end
        if (a == OFS_FILTER) begin
            reg_sel = 3'h4;
        end
    endfunction

    // Per-channel synchroniser and filter
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        icc_filter u_filt (
            .mclk_i    (mclk_i),
            .rst_n_i   (rst_n_i),
            .ce_i      (ce_i),
            .pin_i     (cap_pin_i[c]),
            .filt_on_i (filter_q[FILTER_LSB+c]),
            .level_o   (lvl[c])
        );
    end

    // Edge detection gated by channel enable
    always_comb begin
        lvl_d = lvl;
        for (int c = 0; c < NUM_CHAN; c++) begin
            hit[c] = en_flags_q[ENABLE_LSB+c] &&
                     edge_hit(edge_sel_q[EDGE_W*c +: EDGE_W],
                              lvl_q[c], lvl[c]);
        end
        strobe_d = hit;
    end

    // Register writes and flag setting; a set beats a same-cycle clear
    always_comb begin
        en_flags_d = en_flags_q;
        edge_sel_d = edge_sel_q;
        filter_d   = filter_q;
        if (sfr_wr_i) begin
            unique case (reg_sel(sfr_addr_i))
                3'h1:    en_flags_d = sfr_wdata_i & MASK_EN_FLAGS;
                3'h2:    edge_sel_d = sfr_wdata_i & MASK_EDGE_SEL;
                3'h4:    filter_d   = sfr_wdata_i & MASK_FILTER;
                default: ;
            endcase
        end
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (hit[c]) begin
                en_flags_d[FLAG_LSB+c] = 1'b1;
            end
        end
    end

    // Read data, unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd_i) begin
            unique case (reg_sel(sfr_addr_i))
                3'h1:    rdata_d = en_flags_q;
                3'h2:    rdata_d = edge_sel_q;
                3'h4:    rdata_d = filter_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // State registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            en_flags_q <= RST_EN_FLAGS;
            edge_sel_q <= RST_EDGE_SEL;
            filter_q   <= RST_FILTER;
            rdata_q    <= 8'h00;
            lvl_q      <= '0;
            strobe_q   <= '0;
        end else if (ce_i) begin
            en_flags_q <= en_flags_d;
            edge_sel_q <= edge_sel_d;
            filter_q   <= filter_d;
            rdata_q    <= rdata_d;
            lvl_q      <= lvl_d;
            strobe_q   <= strobe_d;
        end
    end

    assign sfr_rdata_o  = rdata_q;
    assign cap_strobe_o = strobe_q;
    assign cap_flag_o   = en_flags_q[FLAG_LSB +: NUM_CHAN];
endmodule
`default_nettype wire

// ---- verif/icc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model (
    input  wire logic       mclk_i, // Clock
    output logic      [2:0] pin_o   // Pins
);
    initial pin_o = 3'h0;
    // Hold a level for n clocks, then drop low
    task automatic pulse(input logic [2:0] v, input int n);
        pin_o = v;
        repeat (n) @(negedge mclk_i);
        pin_o = 3'h0;
    endtask
endmodule
`default_nettype wire

// ---- verif/icc_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module icc_tb_top;
    import icc_pkg::*;
    logic       mclk = 1'b0;
    logic       rst_n;
    logic [7:0] addr;
    logic [7:0] wd;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [2:0] pin;
    logic [2:0] flag;
    logic       ce;
    logic [2:0] strobe;
    logic [7:0] n_strb = 8'h00;
    logic [7:0] n_dis = 8'h00;
    int         miscompares = 0;
    int         n_tests = 0;
    logic [7:0] ofs [3] = '{8'h92, 8'h93, 8'h94};
    logic [7:0] msk [3] = '{8'h77, 8'h3f, 8'h70};
    // Clock and parts
    always #10 mclk = ~mclk;
    // Count strobe pulses of channel 0 and of disabled channel 1
    always @(negedge mclk) begin
        n_strb <= n_strb + {7'h0, strobe[0]};
        n_dis  <= n_dis + {7'h0, strobe[1]};
    end
    icc_pin_model icc_pin_model_inst (.mclk_i(mclk), .pin_o(pin));
    icc_top icc_top_inst (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce),
        .sfr_addr_i(addr), .sfr_wdata_i(wd), .sfr_wr_i(wr), .sfr_rd_i(rd),
        .sfr_rdata_o(rdata), .cap_pin_i(pin), .cap_strobe_o(strobe),
        .cap_flag_o(flag));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge mclk) wr = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge mclk) rd = 1'b0;
        @(negedge mclk) chk(rdata, exp);
    endtask
    task automatic print_verdict();
        $display("tests=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_n, addr, wd, wr, rd} = 19'h0;
        ce = 1'b1;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd_reg(ofs[i], 8'h00);
            wr_reg(ofs[i], 8'hff);
            rd_reg(ofs[i], msk[i]);
            wr_reg(ofs[i], 8'h00);
        end
        rd_reg(8'h95, 8'h00);
        $display("registers done");
        wr_reg(OFS_EN_FLAGS, 8'h50);
        for (int k = 0; k < 4; k++) begin
            wr_reg(OFS_EDGE_SEL, {2'h0, k[1:0], k[1:0], k[1:0]});
            icc_pin_model_inst.pulse(3'h7, 8);
            chk({5'h0, flag}, (k == 1 || k == 2) ? 8'h05 : 8'h00);
            repeat (8) @(negedge mclk);
            chk({5'h0, flag}, (k < 3) ? 8'h05 : 8'h00);
            wr_reg(OFS_EN_FLAGS, 8'h50);
        end
        chk(n_strb, 8'h04);
        chk(n_dis, 8'h00);
        $display("edges done");
        wr_reg(OFS_EDGE_SEL, 8'h2a);
        wr_reg(OFS_FILTER, 8'h10);
        icc_pin_model_inst.pulse(3'h7, 3);
        repeat (10) @(negedge mclk);
        chk({5'h0, flag}, 8'h04);
        wr_reg(OFS_EN_FLAGS, 8'h50);
        icc_pin_model_inst.pulse(3'h7, 4);
        repeat (10) @(negedge mclk);
        rd_reg(OFS_EN_FLAGS, 8'h55);
        $display("filter done");
        ce = 1'b0;
        wr_reg(OFS_EN_FLAGS, 8'h00);
        repeat (4) @(negedge mclk);
        chk({5'h0, flag}, 8'h05);
        ce = 1'b1;
        rd_reg(OFS_EN_FLAGS, 8'h55);
        $display("freeze done");
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        rd_reg(OFS_EN_FLAGS, 8'h00);
        rd_reg(OFS_FILTER, 8'h00);
        $display("reset done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- verif/icc_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module icc_top_sva
    import icc_pkg::*;
(
    input wire logic                mclk_i,       // Clock
    input wire logic                rst_n_i,      // Reset
    input wire logic                ce_i,         // Enable
    input wire logic [7:0]          sfr_addr_i,   // Address
    input wire logic [7:0]          sfr_wdata_i,  // Data
    input wire logic                sfr_wr_i,     // Write
    input wire logic                sfr_rd_i,     // Read
    input wire logic [7:0]          sfr_rdata_o,  // Read data
    input wire logic [NUM_CHAN-1:0] cap_pin_i,    // Pins
    input wire logic [NUM_CHAN-1:0] cap_strobe_o, // Pulses
    input wire logic [NUM_CHAN-1:0] cap_flag_o    // Flags
);
    logic       wr_ef;
    logic [2:0] en_d;
    logic [2:0] en_q;
    // Shadow of the channel enables
    assign wr_ef = ce_i && sfr_wr_i && sfr_addr_i == OFS_EN_FLAGS;
    always_comb begin
        en_d = wr_ef ? sfr_wdata_i[6:4] : en_q;
    end
    always_ff @(posedge mclk_i) begin
        en_q <= rst_n_i ? en_d : 3'h0;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_rd(a);
        ce_i && sfr_rd_i && sfr_addr_i == a;
    endsequence
    AST_RST: assert property (disable iff (1'b0)
        !rst_n_i |=> {sfr_rdata_o, cap_flag_o, cap_strobe_o} == 14'h0)
        else $error("reset");
    AST_HOLD: assert property (|($past(cap_flag_o) & ~cap_flag_o)
        |-> $past(wr_ef)) else $error("flag dropped");
    AST_SET: assert property ((cap_strobe_o & ~cap_flag_o) == 3'h0)
        else $error("pulse without flag");
    AST_RISE: assert property (
        |(cap_flag_o & ~$past(cap_flag_o) & ~cap_strobe_o) |-> $past(wr_ef))
        else $error("flag cause");
    AST_EN: assert property (
        (cap_strobe_o & ~($past(en_q) | $past(en_q, 2))) == 3'h0)
        else $error("disabled pulse");
    AST_FRZ: assert property (!ce_i && rst_n_i |=>
        $stable(sfr_rdata_o) && $stable(cap_flag_o))
        else $error("state moved while frozen");
    AST_RSV0: assert property (s_rd(OFS_EN_FLAGS) |=>
        (sfr_rdata_o & 8'h88) == 8'h00) else $error("reserved");
    AST_RSV1: assert property (s_rd(OFS_EDGE_SEL) |=>
        (sfr_rdata_o & 8'hc0) == 8'h00) else $error("reserved");
    AST_RSV2: assert property (s_rd(OFS_FILTER) |=>
        (sfr_rdata_o & 8'h8f) == 8'h00) else $error("reserved");
endmodule
bind icc_top icc_top_sva icc_top_sva_inst (.*);
`default_nettype wire
